// ### fpc_pkg.sv
// Constants, symbol tables and coding functions for the 100 Mbit coding sublayer.
package fpc_pkg;

  localparam int NIB_W    = 4;
  localparam int GRP_W    = 5;
  localparam int SCR_W    = 11;
  localparam int SCR_TAP  = 8;
  localparam int SYNC_LEN = 2;

  localparam logic [GRP_W-1:0] GRP_IDLE = 5'h1f;
  localparam logic [GRP_W-1:0] GRP_J    = 5'h18;
  localparam logic [GRP_W-1:0] GRP_K    = 5'h11;
  localparam logic [GRP_W-1:0] GRP_T    = 5'h0d;
  localparam logic [GRP_W-1:0] GRP_R    = 5'h07;
  localparam logic [GRP_W-1:0] GRP_H    = 5'h04;

  localparam logic [NIB_W-1:0] PREAMBLE_NIB = 4'h5;
  localparam logic [NIB_W-1:0] NIB_ZERO     = 4'h0;
  localparam logic [SCR_W-1:0] SCR_SEED     = 11'h000;

  typedef enum logic [2:0] {
    FPC_SYM_DATA = 3'b000,
    FPC_SYM_IDLE = 3'b001,
    FPC_SYM_J    = 3'b010,
    FPC_SYM_K    = 3'b011,
    FPC_SYM_T    = 3'b100,
    FPC_SYM_R    = 3'b101,
    FPC_SYM_H    = 3'b110,
    FPC_SYM_BAD  = 3'b111
  } fpc_sym_t;

  function automatic logic [GRP_W-1:0] fpc_encode(input logic [NIB_W-1:0] nib);
    logic [GRP_W-1:0] g;
    g = GRP_IDLE;
    case (nib)
      4'h0: g = 5'h1e;
      4'h1: g = 5'h09;
      4'h2: g = 5'h14;
      4'h3: g = 5'h15;
      4'h4: g = 5'h0a;
      4'h5: g = 5'h0b;
      4'h6: g = 5'h0e;
      4'h7: g = 5'h0f;
      4'h8: g = 5'h12;
      4'h9: g = 5'h13;
      4'ha: g = 5'h16;
      4'hb: g = 5'h17;
      4'hc: g = 5'h1a;
      4'hd: g = 5'h1b;
      4'he: g = 5'h1c;
      4'hf: g = 5'h1d;
      default: g = GRP_IDLE;
    endcase
    return g;
  endfunction

  // Reverse lookup; groups that are not data return zero.
  function automatic logic [NIB_W-1:0] fpc_decode(input logic [GRP_W-1:0] g);
    logic [NIB_W-1:0] n;
    n = NIB_ZERO;
    for (int i = 0; i < 16; i++) begin
      if (fpc_encode(i[NIB_W-1:0]) == g) begin
        n = i[NIB_W-1:0];
      end
    end
    return n;
  endfunction

  function automatic fpc_sym_t fpc_classify(input logic [GRP_W-1:0] g);
    fpc_sym_t s;
    s = FPC_SYM_BAD;
    if (fpc_encode(fpc_decode(g)) == g) begin
      s = FPC_SYM_DATA;
    end else if (g == GRP_IDLE) begin
      s = FPC_SYM_IDLE;
    end else if (g == GRP_J) begin
      s = FPC_SYM_J;
    end else if (g == GRP_K) begin
      s = FPC_SYM_K;
    end else if (g == GRP_T) begin
      s = FPC_SYM_T;
    end else if (g == GRP_R) begin
      s = FPC_SYM_R;
    end else if (g == GRP_H) begin
      s = FPC_SYM_H;
    end
    return s;
  endfunction

endpackage

// ### fpc_rx_link.sv
// Link-clock capture of received code groups with a toggle handover.
`timescale 1ns/1ps
module fpc_rx_link
  import fpc_pkg::*;
#(
  parameter int GW = fpc_pkg::GRP_W
) (
  input  wire logic          link_clk,
  input  wire logic          sys_rst,
  input  wire logic [GW-1:0] line_grp,
  output logic      [GW-1:0] grp_hold,
  output logic               grp_toggle
);

  logic [SYNC_LEN-1:0] rst_sync_reg;
  logic [SYNC_LEN-1:0] rst_sync_next;
  logic [GW-1:0]       grp_reg;
  logic [GW-1:0]       grp_next;
  logic                tog_reg;
  logic                tog_next;
  logic                link_rst;

  // The reset is brought into this domain so only the first synchroniser flop sees the core reset directly.
  assign link_rst = rst_sync_reg[SYNC_LEN-1];

  always_comb begin
    rst_sync_next = {rst_sync_reg[SYNC_LEN-2:0], sys_rst};
    grp_next      = line_grp;
    tog_next      = ~tog_reg;
    if (link_rst) begin
      grp_next = GRP_IDLE;
      tog_next = 1'b0;
    end
  end

  // The held group stays stable for a whole link period after each toggle,
  // longer than the core synchroniser needs, so no wider handshake is used.
  always_ff @(posedge link_clk) begin
    rst_sync_reg <= rst_sync_next;
    grp_reg      <= grp_next;
    tog_reg      <= tog_next;
  end

  assign grp_hold   = grp_reg;
  assign grp_toggle = tog_reg;

endmodule

// ### fpc_codec.sv
// 100 Mbit coding sublayer: nibble to code-group transmit and receive paths.
`timescale 1ns/1ps
// Function
// - With transmit enable low at 100 Mbit, Idle groups go to the line driver.
// - The line carries 5-bit groups; the MAC side carries one 4-bit nibble each.
// - Nibbles 0 to 7 encode per the data table; decoding reverses it.
// - Nibbles 8 to F encode per the data table; decoding reverses it.
// - Idle groups fill the line continuously between frames.
// - Start delimiter is J 11000 then K 10001, always as a pair.
// - End delimiter is T 01101 then R 00111.
// - Group H 00100 forces a line error and signals an error condition.
// - The ten invalid groups raise receive error when received.
// - The first two nibbles of a frame are replaced by J and K.
// - Remaining preamble, delimiter, data and CRC are coded in order.
// - After transmit enable drops, send T and R, then Idle.
// - A received J and K becomes two preamble nibbles to the MAC.
// - Twisted-pair mode scrambles transmit groups and descrambles received ones.
// - Fiber mode sends and receives the stream as NRZI.
// - 10 Mbit mode bypasses the encoder and decoder, passing nibbles only.
// - Carrier sense rises on J and K and falls on T and R.
// - Idle without T and R drops carrier and pulses receive error once.
// - Collision is high whenever transmit and receive overlap.
module fpc_codec
  import fpc_pkg::*;
(
  input  wire logic                       CORE_CLK,
  input  wire logic                       SYS_RST,
  input  wire logic                       LINK_CLK,
  input  wire logic                       TX_EN,
  input  wire logic                       TX_ER,
  input  wire logic [fpc_pkg::NIB_W-1:0]  TXD,
  input  wire logic                       SPEED_100,
  input  wire logic                       FIBER_MODE,
  input  wire logic [fpc_pkg::GRP_W-1:0]  RX_LINE_GRP,
  output logic      [fpc_pkg::GRP_W-1:0]  TX_LINE_GRP,
  output logic      [fpc_pkg::NIB_W-1:0]  RXD,
  output logic                            RX_STB,
  output logic                            RX_DV,
  output logic                            RX_ER,
  output logic                            CRS,
  output logic                            COL
);
  import fpc_pkg::*;

  typedef enum logic [1:0] {
    FPC_TX_IDLE = 2'b00,
    FPC_TX_K    = 2'b01,
    FPC_TX_DATA = 2'b10,
    FPC_TX_R    = 2'b11
  } fpc_tx_st_t;

  typedef enum logic [1:0] {
    FPC_RX_IDLE = 2'b00,
    FPC_RX_J    = 2'b01,
    FPC_RX_DATA = 2'b10,
    FPC_RX_T    = 2'b11
  } fpc_rx_st_t;

  // Serial multiplicative scrambler, most significant bit goes out first.
  function automatic logic [SCR_W+GRP_W-1:0] scramble(input logic [GRP_W-1:0] d,
                                                       input logic [SCR_W-1:0] h_in);
    logic [SCR_W-1:0] h;
    logic [GRP_W-1:0] s;
    h = h_in;
    s = '0;
    for (int i = GRP_W - 1; i >= 0; i--) begin
      s[i] = d[i] ^ h[SCR_TAP] ^ h[SCR_W-1];
      h    = {h[SCR_W-2:0], s[i]};
    end
    return {h, s};
  endfunction

  // Self-synchronising: history holds line bits, so it locks after eleven bits.
  function automatic logic [SCR_W+GRP_W-1:0] descramble(input logic [GRP_W-1:0] s,
                                                         input logic [SCR_W-1:0] h_in);
    logic [SCR_W-1:0] h;
    logic [GRP_W-1:0] d;
    h = h_in;
    d = '0;
    for (int i = GRP_W - 1; i >= 0; i--) begin
      d[i] = s[i] ^ h[SCR_TAP] ^ h[SCR_W-1];
      h    = {h[SCR_W-2:0], s[i]};
    end
    return {h, d};
  endfunction

  // NRZI: a one toggles the line level, a zero holds it.
  function automatic logic [GRP_W-1:0] nrzi_enc(input logic [GRP_W-1:0] d, input logic lvl_in);
    logic             lvl;
    logic [GRP_W-1:0] o;
    lvl = lvl_in;
    o   = '0;
    for (int i = GRP_W - 1; i >= 0; i--) begin
      lvl  = lvl ^ d[i];
      o[i] = lvl;
    end
    return o;
  endfunction

  function automatic logic [GRP_W-1:0] nrzi_dec(input logic [GRP_W-1:0] l, input logic lvl_in);
    logic [GRP_W-1:0] prev;
    prev = {lvl_in, l[GRP_W-1:1]};
    return l ^ prev;
  endfunction

  // ---- Pin synchronisers and receive handover --------------------------------
  logic [SYNC_LEN-1:0] spd_sync_reg, spd_sync_next;
  logic [SYNC_LEN-1:0] fib_sync_reg, fib_sync_next;
  logic [SYNC_LEN:0]   tog_sync_reg, tog_sync_next;
  logic [GRP_W-1:0]    link_grp;
  logic                link_tog;
  logic                speed100;
  logic                fiber;
  logic                grp_new;

  fpc_rx_link #(.GW(GRP_W)) u_rx_link (
    .link_clk   (LINK_CLK),
    .sys_rst    (SYS_RST),
    .line_grp   (RX_LINE_GRP),
    .grp_hold   (link_grp),
    .grp_toggle (link_tog)
  );

  assign speed100 = spd_sync_reg[SYNC_LEN-1];
  assign fiber    = fib_sync_reg[SYNC_LEN-1];
  assign grp_new  = tog_sync_reg[SYNC_LEN] ^ tog_sync_reg[SYNC_LEN-1];

  always_comb begin
    spd_sync_next = {spd_sync_reg[SYNC_LEN-2:0], SPEED_100};
    fib_sync_next = {fib_sync_reg[SYNC_LEN-2:0], FIBER_MODE};
    tog_sync_next = {tog_sync_reg[SYNC_LEN-1:0], link_tog};
    if (SYS_RST) begin
      spd_sync_next = '0;
      fib_sync_next = '0;
      tog_sync_next = '0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    spd_sync_reg <= spd_sync_next;
    fib_sync_reg <= fib_sync_next;
    tog_sync_reg <= tog_sync_next;
  end

  // ---- Transmit path ---------------------------------------------------------
  fpc_tx_st_t       tx_st_reg, tx_st_next;
  logic [GRP_W-1:0] tx_grp_reg, tx_grp_next;
  logic [SCR_W-1:0] tx_scr_reg, tx_scr_next;
  logic             tx_lvl_reg, tx_lvl_next;
  logic             tx_act_reg, tx_act_next;
  logic [GRP_W-1:0] tx_code;
  logic [SCR_W+GRP_W-1:0] tx_scr_res;

  always_comb begin
    tx_st_next  = tx_st_reg;
    tx_code     = GRP_IDLE;
    tx_act_next = 1'b0;
    unique case (tx_st_reg)
      FPC_TX_IDLE: begin
        if (TX_EN) begin
          tx_code     = GRP_J;
          tx_act_next = 1'b1;
          tx_st_next  = FPC_TX_K;
        end
      end
      FPC_TX_K: begin
        tx_code     = GRP_K;
        tx_act_next = 1'b1;
        tx_st_next  = FPC_TX_DATA;
      end
      FPC_TX_DATA: begin
        tx_act_next = 1'b1;
        if (!TX_EN) begin
          tx_code    = GRP_T;
          tx_st_next = FPC_TX_R;
        end else if (TX_ER) begin
          tx_code = GRP_H;
        end else begin
          tx_code = fpc_encode(TXD);
        end
      end
      FPC_TX_R: begin
        tx_code     = GRP_R;
        tx_act_next = 1'b1;
        tx_st_next  = FPC_TX_IDLE;
      end
    endcase

    // One group leaves per clock, so the line rate follows the nibble rate.
    tx_scr_res  = scramble(tx_code, tx_scr_reg);
    tx_scr_next = tx_scr_reg;
    tx_lvl_next = tx_lvl_reg;
    if (!speed100) begin
      tx_grp_next = {1'b0, TXD};
      tx_act_next = TX_EN;
      tx_st_next  = FPC_TX_IDLE;
      if (!TX_EN) begin
        tx_grp_next = '0;
      end
    end else if (fiber) begin
      tx_grp_next = nrzi_enc(tx_code, tx_lvl_reg);
      tx_lvl_next = tx_grp_next[0];
    end else begin
      tx_grp_next = tx_scr_res[GRP_W-1:0];
      tx_scr_next = tx_scr_res[SCR_W+GRP_W-1:GRP_W];
    end

    if (SYS_RST) begin
      tx_st_next  = FPC_TX_IDLE;
      tx_grp_next = GRP_IDLE;
      tx_scr_next = SCR_SEED;
      tx_lvl_next = 1'b0;
      tx_act_next = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    tx_st_reg  <= tx_st_next;
    tx_grp_reg <= tx_grp_next;
    tx_scr_reg <= tx_scr_next;
    tx_lvl_reg <= tx_lvl_next;
    tx_act_reg <= tx_act_next;
  end

  // ---- Receive path ----------------------------------------------------------
  fpc_rx_st_t       rx_st_reg, rx_st_next;
  logic [SCR_W-1:0] rx_scr_reg, rx_scr_next;
  logic             rx_lvl_reg, rx_lvl_next;
  logic [NIB_W-1:0] rxd_reg, rxd_next;
  logic             stb_reg, stb_next;
  logic             dv_reg, dv_next;
  logic             er_reg, er_next;
  logic             crs_reg, crs_next;
  logic             col_reg, col_next;
  logic             pre2_reg, pre2_next;
  logic [GRP_W-1:0] rx_grp;
  logic [SCR_W+GRP_W-1:0] rx_dsc_res;
  fpc_sym_t         sym;

  always_comb begin
    rx_st_next  = rx_st_reg;
    rx_scr_next = rx_scr_reg;
    rx_lvl_next = rx_lvl_reg;
    rxd_next    = rxd_reg;
    stb_next    = 1'b0;
    dv_next     = dv_reg;
    er_next     = 1'b0;
    crs_next    = crs_reg;
    pre2_next   = 1'b0;
    rx_dsc_res  = descramble(link_grp, rx_scr_reg);
    rx_grp      = link_grp;
    if (fiber) begin
      rx_grp = nrzi_dec(link_grp, rx_lvl_reg);
    end else begin
      rx_grp = rx_dsc_res[GRP_W-1:0];
    end
    sym = fpc_classify(rx_grp);

    // The second preamble nibble goes out one clock after the first.
    if (pre2_reg) begin
      rxd_next = PREAMBLE_NIB;
      stb_next = 1'b1;
    end

    if (grp_new && !speed100) begin
      rxd_next   = link_grp[NIB_W-1:0];
      dv_next    = link_grp[GRP_W-1];
      crs_next   = link_grp[GRP_W-1];
      stb_next   = link_grp[GRP_W-1];
      rx_st_next = FPC_RX_IDLE;
    end else if (grp_new) begin
      rx_lvl_next = link_grp[0];
      if (!fiber) begin
        rx_scr_next = rx_dsc_res[SCR_W+GRP_W-1:GRP_W];
      end
      if (sym == FPC_SYM_BAD) begin
        er_next = 1'b1;
      end
      unique case (rx_st_reg)
        FPC_RX_IDLE: begin
          if (sym == FPC_SYM_J) begin
            rx_st_next = FPC_RX_J;
          end
        end
        FPC_RX_J: begin
          rx_st_next = FPC_RX_IDLE;
          if (sym == FPC_SYM_K) begin
            rx_st_next = FPC_RX_DATA;
            crs_next   = 1'b1;
            dv_next    = 1'b1;
            rxd_next   = PREAMBLE_NIB;
            stb_next   = 1'b1;
            pre2_next  = 1'b1;
          end
        end
        FPC_RX_DATA: begin
          if (sym == FPC_SYM_DATA) begin
            rxd_next = fpc_decode(rx_grp);
            stb_next = 1'b1;
          end else if (sym == FPC_SYM_T) begin
            rx_st_next = FPC_RX_T;
            dv_next    = 1'b0;
          end else if (sym == FPC_SYM_IDLE) begin
            rx_st_next = FPC_RX_IDLE;
            crs_next   = 1'b0;
            dv_next    = 1'b0;
            er_next    = 1'b1;
          end else begin
            er_next  = 1'b1;
            stb_next = 1'b1;
          end
        end
        FPC_RX_T: begin
          if (sym == FPC_SYM_R) begin
            rx_st_next = FPC_RX_IDLE;
            crs_next   = 1'b0;
          end else if (sym == FPC_SYM_IDLE) begin
            rx_st_next = FPC_RX_IDLE;
            crs_next   = 1'b0;
            er_next    = 1'b1;
          end else begin
            rx_st_next = FPC_RX_DATA;
            er_next    = 1'b1;
          end
        end
      endcase
    end

    col_next = tx_act_reg && crs_reg;

    if (SYS_RST) begin
      rx_st_next  = FPC_RX_IDLE;
      rx_scr_next = SCR_SEED;
      rx_lvl_next = 1'b0;
      rxd_next    = NIB_ZERO;
      stb_next    = 1'b0;
      dv_next     = 1'b0;
      er_next     = 1'b0;
      crs_next    = 1'b0;
      col_next    = 1'b0;
      pre2_next   = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    rx_st_reg  <= rx_st_next;
    rx_scr_reg <= rx_scr_next;
    rx_lvl_reg <= rx_lvl_next;
    rxd_reg    <= rxd_next;
    stb_reg    <= stb_next;
    dv_reg     <= dv_next;
    er_reg     <= er_next;
    crs_reg    <= crs_next;
    col_reg    <= col_next;
    pre2_reg   <= pre2_next;
  end

  assign TX_LINE_GRP = tx_grp_reg;
  assign RXD         = rxd_reg;
  assign RX_STB      = stb_reg;
  assign RX_DV       = dv_reg;
  assign RX_ER       = er_reg;
  assign CRS         = crs_reg;
  assign COL         = col_reg;

endmodule

// ### fpc_codec_props.sv
// Concurrent checks of the coding sublayer at its ports.
`timescale 1ns/1ps
module fpc_codec_props
  import fpc_pkg::*;
(
  input wire logic                      CORE_CLK,
  input wire logic                      SYS_RST,
  input wire logic                      TX_EN,
  input wire logic                      TX_ER,
  input wire logic [fpc_pkg::NIB_W-1:0] TXD,
  input wire logic                      SPEED_100,
  input wire logic                      FIBER_MODE,
  input wire logic [fpc_pkg::GRP_W-1:0] TX_LINE_GRP,
  input wire logic [fpc_pkg::NIB_W-1:0] RXD,
  input wire logic                      RX_STB,
  input wire logic                      RX_DV,
  input wire logic                      RX_ER,
  input wire logic                      CRS,
  input wire logic                      COL
);
  localparam logic [GRP_W-1:0] ENC_TAB [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
    5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  logic [2:0]       mode_cnt_reg;
  logic [2:0]       mode_cnt_next;
  logic             last_bit_reg;
  logic             last_bit_next;
  logic [GRP_W-1:0] dec;
  logic             fib;

  // Line groups are only judged once both mode pins have passed their synchronisers.
  always_comb begin
    mode_cnt_next = mode_cnt_reg;
    if (!(SPEED_100 && FIBER_MODE)) begin
      mode_cnt_next = 3'h0;
    end else if (mode_cnt_reg != 3'h7) begin
      mode_cnt_next = mode_cnt_reg + 3'h1;
    end
    last_bit_next = TX_LINE_GRP[0];
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      mode_cnt_reg <= 3'h0;
      last_bit_reg <= 1'b0;
    end else begin
      mode_cnt_reg <= mode_cnt_next;
      last_bit_reg <= last_bit_next;
    end
  end

  assign fib = (mode_cnt_reg == 3'h7);
  assign dec = TX_LINE_GRP ^ {last_bit_reg, TX_LINE_GRP[4:1]};

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);

  sequence s_ssd;
    dec == GRP_J ##1 dec == GRP_K;
  endsequence
  sequence s_esd;
    dec == GRP_T ##1 dec == GRP_R;
  endsequence
  sequence s_pre;
    RX_STB && RXD == PREAMBLE_NIB ##1 RX_STB && RXD == PREAMBLE_NIB;
  endsequence

  AST_IDLE_FILL:
    assert property ((fib && !TX_EN) [*3] |=> dec == GRP_IDLE) else $error("idle missing");
  AST_SSD_PAIR:
    assert property ((fib && !TX_EN) [*3] ##1 TX_EN |=> s_ssd) else $error("bad start pair");
  AST_DATA_ENC:
    assert property ((fib && TX_EN) [*2] ##1 (fib && TX_EN && !TX_ER)
      |=> dec == ENC_TAB[$past(TXD)]) else $error("bad data group");
  AST_ERR_H:
    assert property ((fib && TX_EN) [*2] ##1 (fib && TX_EN && TX_ER)
      |=> dec == GRP_H) else $error("error group missing");
  AST_ESD_PAIR:
    assert property ((fib && TX_EN) ##1 (fib && !TX_EN) |=> s_esd) else $error("bad end pair");
  AST_COL_SET:
    assert property ((fib && TX_EN && CRS) [*5] |-> COL) else $error("collision missed");
  AST_COL_CLEAR:
    assert property (!CRS [*3] |-> !COL) else $error("collision without carrier");
  AST_ER_PULSE:
    assert property (RX_ER |=> !RX_ER) else $error("receive error too long");
  AST_DV_CRS:
    assert property (RX_DV |-> CRS) else $error("valid without carrier");
  AST_SSD_RX:
    assert property (fib && $rose(CRS) |-> s_pre) else $error("preamble not restored");
endmodule

bind fpc_codec fpc_codec_props i_fpc_codec_props (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .TX_EN(TX_EN), .TX_ER(TX_ER), .TXD(TXD),
  .SPEED_100(SPEED_100), .FIBER_MODE(FIBER_MODE), .TX_LINE_GRP(TX_LINE_GRP), .RXD(RXD),
  .RX_STB(RX_STB), .RX_DV(RX_DV), .RX_ER(RX_ER), .CRS(CRS), .COL(COL)
);

// ### fpc_line_peer.sv
// Far-end line sender: queued code groups go out NRZI coded, Idle fills the gaps.
`timescale 1ns/1ps
module fpc_line_peer
  import fpc_pkg::*;
(
  input  wire logic             link_clk,
  input  wire logic             rst,
  output logic      [GRP_W-1:0] line_grp,
  output logic                  drained
);
  logic [GRP_W-1:0] pend[$];
  logic [GRP_W-1:0] sym;
  logic             lvl;

  task automatic push(input logic [GRP_W-1:0] g);
    pend.push_back(g);
  endtask

  // A flat line during reset leaves both ends' NRZI level at zero when it lifts.
  always @(posedge link_clk) begin
    if (rst) begin
      lvl = 1'b0;
      line_grp <= 5'h00;
      drained <= 1'b1;
    end else begin
      sym = (pend.size() > 0) ? pend.pop_front() : GRP_IDLE;
      drained <= (pend.size() == 0);
      for (int b = GRP_W - 1; b >= 0; b--) begin
        lvl = lvl ^ sym[b];
        line_grp[b] <= lvl;
      end
    end
  end
endmodule

// ### test_fast_ethernet_pcs_4b5b_codec.sv
// Self-checking bench for the coding sublayer against a far-end line model.
`timescale 1ns/1ps
`define CHECK(got, exp) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
  end
module test_fast_ethernet_pcs_4b5b_codec;
  import fpc_pkg::*;
  localparam logic [GRP_W-1:0] ENC_TAB [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b,
    5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  logic             core_clk, link_clk, sys_rst, tx_en, tx_er, speed_100, fiber_mode;
  logic             rx_stb, rx_dv, rx_er, crs, col, drained, cap, last_bit, peer_hold;
  logic [SCR_W-1:0] dsc_h;
  logic [GRP_W-1:0] dsc_g;
  logic [NIB_W-1:0] txd, rxd;
  logic [GRP_W-1:0] tx_line_grp, rx_line_grp;
  logic [GRP_W-1:0] tx_q[$];
  logic [NIB_W-1:0] rx_q[$];
  int               mismatches, num_checks, n_er, n_col;

  fpc_codec i_fpc_codec (.CORE_CLK(core_clk), .SYS_RST(sys_rst), .LINK_CLK(link_clk),
    .TX_EN(tx_en), .TX_ER(tx_er), .TXD(txd), .SPEED_100(speed_100), .FIBER_MODE(fiber_mode),
    .RX_LINE_GRP(rx_line_grp), .TX_LINE_GRP(tx_line_grp), .RXD(rxd), .RX_STB(rx_stb),
    .RX_DV(rx_dv), .RX_ER(rx_er), .CRS(crs), .COL(col));
  fpc_line_peer i_fpc_line_peer (.link_clk(link_clk), .rst(sys_rst | peer_hold),
    .line_grp(rx_line_grp),
    .drained(drained));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #62.5 link_clk = ~link_clk;
  end

  // Outputs are read on the falling edge, after every registered update has landed.
  // The descrambler keeps line bits as history, so it locks on its own after eleven bits.
  always @(negedge core_clk) begin
    for (int b = GRP_W - 1; b >= 0; b--) begin
      dsc_g[b] = tx_line_grp[b] ^ dsc_h[SCR_TAP] ^ dsc_h[SCR_W-1];
      dsc_h    = {dsc_h[SCR_W-2:0], tx_line_grp[b]};
    end
    if (cap) tx_q.push_back(fiber_mode ? (tx_line_grp ^ {last_bit, tx_line_grp[4:1]}) : dsc_g);
    last_bit = tx_line_grp[0];
    if (rx_stb === 1'b1) rx_q.push_back(rxd);
    if (rx_er === 1'b1) n_er++;
    if (col === 1'b1) n_col++;
  end

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic line_send(input logic [GRP_W-1:0] gs[$]);
    foreach (gs[i]) i_fpc_line_peer.push(gs[i]);
  endtask

  // The peer flag is stale until a link edge has passed, so polling starts late.
  task automatic wait_drained();
    int n;
    n = 0;
    repeat (4) @(posedge core_clk);
    while (drained !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 400) begin
      mismatches++;
      tally_and_finish();
    end
    repeat (12) @(posedge core_clk);
  endtask

  task automatic tx_frame(input int len, input int er_at);
    logic [GRP_W-1:0] exp[$];
    logic [NIB_W-1:0] nib;
    exp = '{GRP_IDLE, GRP_J, GRP_K};
    tx_q.delete();
    @(posedge core_clk);
    cap <= 1'b1;
    for (int i = 0; i < len; i++) begin
      nib = (i < 7) ? PREAMBLE_NIB : 4'(i + 9);
      tx_en <= 1'b1;
      tx_er <= (i == er_at);
      txd <= nib;
      if (i >= 2) exp.push_back((i == er_at) ? GRP_H : ENC_TAB[nib]);
      @(posedge core_clk);
    end
    tx_en <= 1'b0;
    tx_er <= 1'b0;
    exp.push_back(GRP_T);
    exp.push_back(GRP_R);
    exp.push_back(GRP_IDLE);
    repeat (4) @(posedge core_clk);
    cap <= 1'b0;
    `CHECK(tx_q.size(), exp.size())
    foreach (exp[i]) `CHECK(tx_q[i], exp[i])
  endtask

  task automatic rx_frame();
    logic [NIB_W-1:0] exp[$];
    rx_q.delete();
    n_er = 0;
    exp = '{PREAMBLE_NIB, PREAMBLE_NIB};
    line_send('{GRP_J, GRP_K});
    for (int i = 0; i < 16; i++) begin
      line_send('{ENC_TAB[i]});
      exp.push_back(4'(i));
    end
    line_send('{GRP_T, GRP_R});
    wait_drained();
    `CHECK(rx_q.size(), exp.size())
    foreach (exp[i]) `CHECK(rx_q[i], exp[i])
    `CHECK(n_er, 0)
    `CHECK(crs, 1'b0)
    `CHECK(rx_dv, 1'b0)
  endtask

  task automatic rx_errors();
    logic [GRP_W-1:0] bad[$];
    bad = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h19};
    n_er = 0;
    foreach (bad[i]) line_send('{bad[i], GRP_IDLE});
    wait_drained();
    `CHECK(n_er, 10)
    n_er = 0;
    line_send('{GRP_J, GRP_K, ENC_TAB[3], GRP_H, GRP_IDLE, GRP_IDLE});
    wait_drained();
    `CHECK(n_er, 2)
    `CHECK(crs, 1'b0)
  endtask

  // The far end is held flat here, since its coding only makes sense in fiber mode.
  task automatic alt_modes();
    @(posedge core_clk);
    peer_hold <= 1'b1;
    fiber_mode <= 1'b0;
    repeat (20) @(posedge core_clk);
    tx_frame(10, 5);
    speed_100 <= 1'b0;
    repeat (4) @(posedge core_clk);
    tx_en <= 1'b1;
    txd <= 4'ha;
    @(posedge core_clk);
    tx_en <= 1'b0;
    @(negedge core_clk);
    `CHECK(tx_line_grp, {1'b0, 4'ha})
    @(negedge core_clk);
    `CHECK(tx_line_grp, 5'h00)
    @(posedge core_clk);
    speed_100 <= 1'b1;
    fiber_mode <= 1'b1;
    peer_hold <= 1'b0;
    repeat (20) @(posedge core_clk);
  endtask

  task automatic collide();
    n_col = 0;
    line_send('{GRP_J, GRP_K});
    for (int i = 0; i < 16; i++) line_send('{ENC_TAB[i]});
    line_send('{GRP_T, GRP_R});
    repeat (10) @(posedge core_clk);
    tx_frame(23, 12);
    wait_drained();
    `CHECK(n_col > 0, 1'b1)
    `CHECK(col, 1'b0)
  endtask

  initial begin
    sys_rst = 1'b1;
    tx_en = 1'b0;
    tx_er = 1'b0;
    txd = 4'h0;
    speed_100 = 1'b1;
    fiber_mode = 1'b1;
    cap = 1'b0;
    last_bit = 1'b0;
    peer_hold = 1'b0;
    dsc_h = '0;
    mismatches = 0;
    num_checks = 0;
    n_er = 0;
    n_col = 0;
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge core_clk);
    tx_frame(23, 30);
    tx_frame(6, 3);
    alt_modes();
    rx_frame();
    rx_errors();
    collide();
    tally_and_finish();
  end
endmodule
